//--- hw/lbu_map.svh
// register offsets, field positions, reset values and codes of the logic/bit-op unit
// assumes: included by bare name wherever a constant is needed
`ifndef LBU_MAP_SVH
`define LBU_MAP_SVH

// ----------------------------------------------------------------
// apb byte offsets
// ----------------------------------------------------------------
`define LBU_CMD_OFF       12'h000
`define LBU_WREG_OFF      12'h004
`define LBU_FLAGS_OFF     12'h008
`define LBU_STATUS_OFF    12'h00c
`define LBU_A_DATA_OFF    12'h010
`define LBU_A_DIR_OFF     12'h014
`define LBU_B_DATA_OFF    12'h018
`define LBU_B_DIR_OFF     12'h01c
`define LBU_A_PIN_OFF     12'h020
`define LBU_B_PIN_OFF     12'h024
`define LBU_MEM_BASE      12'h100

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LBU_CMD_OP_LSB    0
`define LBU_CMD_BIT_LSB   5
`define LBU_CMD_IMM_LSB   8
`define LBU_CMD_ADDR_LSB  16
`define LBU_CMD_WIDTH     24
`define LBU_FLAG_ZERO     0
`define LBU_FLAG_CARRY    1
`define LBU_FLAG_NIBBLE   2
`define LBU_FLAG_SIGNED   3
`define LBU_STATUS_BUSY   0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LBU_WREG_RST      8'h00
`define LBU_FLAGS_RST     4'h0
`define LBU_PORT_RST      8'h00
`define LBU_CMD_RST       24'h000000

// ----------------------------------------------------------------
// io register select codes (low two bits of the command address)
// ----------------------------------------------------------------
`define LBU_IO_A_DATA     2'h0
`define LBU_IO_A_DIR      2'h1
`define LBU_IO_B_DATA     2'h2
`define LBU_IO_B_DIR      2'h3

`endif

//--- hw/lbu_mem.sv
// single-port byte memory standing in for the data memory of the unit
// assumes: one access per cycle, read data valid one cycle after re
`timescale 1ns/1ps
`default_nettype none

module lbu_mem #(
   parameter int DEPTH = 64,
   parameter int AW    = $clog2(DEPTH)
) (
   // clock
   input  wire logic          pclk,
   // access port
   input  wire logic          re,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   logic [7:0] mem_array [DEPTH];

   // no reset on the array: contents are undefined until written
   always_ff @(posedge pclk) begin
      if (we) begin
         mem_array[addr] <= wdata;
      end
      if (re) begin
         rdata <= mem_array[addr];
      end
   end
endmodule

`default_nettype wire

//--- hw/lbu_pkg.sv
// types shared by the logic/bit-op unit
// assumes: compiled before every module of the unit
package lbu_pkg;

   typedef enum logic [4:0] {
      LBU_OP_AND_I    = 5'h00,
      LBU_OP_AND_M    = 5'h01,
      LBU_OP_AND_MW   = 5'h02,
      LBU_OP_OR_I     = 5'h03,
      LBU_OP_OR_M     = 5'h04,
      LBU_OP_OR_MW    = 5'h05,
      LBU_OP_XOR_I    = 5'h06,
      LBU_OP_XOR_M    = 5'h07,
      LBU_OP_XOR_MW   = 5'h08,
      LBU_OP_XOR_IO   = 5'h09,
      LBU_OP_NOT_W    = 5'h0a,
      LBU_OP_NOT_M    = 5'h0b,
      LBU_OP_NEG_W    = 5'h0c,
      LBU_OP_NEG_M    = 5'h0d,
      LBU_OP_BCLR_IO  = 5'h0e,
      LBU_OP_BSET_IO  = 5'h0f,
      LBU_OP_SWAPC_IO = 5'h10,
      LBU_OP_BCLR_M   = 5'h11,
      LBU_OP_BSET_M   = 5'h12
   } lbu_op_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] imm;
      logic [2:0] bit_idx;
      lbu_op_t    op;
   } lbu_cmd_t;

   typedef struct packed {
      logic signed_range;
      logic nibble_carry;
      logic carry;
      logic zero;
   } lbu_flags_t;

   typedef enum logic [2:0] {
      LBU_ST_IDLE  = 3'b001,
      LBU_ST_FETCH = 3'b010,
      LBU_ST_EXEC  = 3'b100
   } lbu_state_t;

endpackage

//--- hw/lbu_top.sv
// logic and single-bit operation unit with its apb register file and two 8-bit ports
// assumes: apb master on pclk, port pins asynchronous to pclk
//
// Function
// - and of working register with immediate/memory
// - or of working register with immediate/memory
// - xor of working register with immediate/memory
// - io xor writes io register, flags kept
// - logic and complement ops update zero only
// - register one's complement inverts working register
// - memory one's complement inverts byte in place
// - register negate: inverse plus one, mod 256
// - memory negate: inverse plus one, in place
// - io bit clear, others and flags kept
// - io bit set, others and flags kept
// - io bit swaps with carry, only carry changes
// - output bit receives prior carry
// - input bit loads pin level into carry
// - direction bit one means output pin
// - memory bit clear, read-modify-write, flags kept
// - memory bit set, read-modify-write, flags kept
`timescale 1ns/1ps
`default_nettype none

`include "lbu_map.svh"

module lbu_top import lbu_pkg::*; #(
   parameter int MEM_DEPTH = 64
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // port a
   input  wire logic [7:0]  port_a_in,
   output logic      [7:0]  port_a_out,
   output logic      [7:0]  port_a_oe,
   // port b
   input  wire logic [7:0]  port_b_in,
   output logic      [7:0]  port_b_out,
   output logic      [7:0]  port_b_oe
);
   localparam int AW = $clog2(MEM_DEPTH);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   lbu_state_t  state_reg;
   lbu_state_t  state_next;
   lbu_cmd_t    cmd_reg;
   lbu_flags_t  flags_reg;
   logic [7:0]  wreg_reg;
   logic [7:0]  port_a_data_reg, port_a_dir_reg;
   logic [7:0]  port_b_data_reg, port_b_dir_reg;
   logic [7:0]  port_a_meta_reg, port_a_sync_reg;
   logic [7:0]  port_b_meta_reg, port_b_sync_reg;
   logic        rd_pend_reg, pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   logic [7:0]  mem_rdata;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire         idle      = (state_reg == LBU_ST_IDLE);
   wire         apb_acc   = psel & penable & ~pready_reg;
   wire         apb_done  = psel & penable & pready_reg;
   wire         hit_cmd   = (paddr == `LBU_CMD_OFF);
   wire         hit_wreg  = (paddr == `LBU_WREG_OFF);
   wire         hit_flags = (paddr == `LBU_FLAGS_OFF);
   wire         hit_stat  = (paddr == `LBU_STATUS_OFF);
   wire         hit_a_dat = (paddr == `LBU_A_DATA_OFF);
   wire         hit_a_dir = (paddr == `LBU_A_DIR_OFF);
   wire         hit_b_dat = (paddr == `LBU_B_DATA_OFF);
   wire         hit_b_dir = (paddr == `LBU_B_DIR_OFF);
   wire         hit_a_pin = (paddr == `LBU_A_PIN_OFF);
   wire         hit_b_pin = (paddr == `LBU_B_PIN_OFF);
   wire [11:0]  mem_off   = paddr - `LBU_MEM_BASE;
   wire         hit_mem   = (paddr >= `LBU_MEM_BASE) && (mem_off[1:0] == 2'h0)
                            && ({20'h00000, mem_off} < 32'(MEM_DEPTH * 4));
   wire         hit_ctl   = hit_cmd | hit_wreg | hit_flags | hit_a_dat | hit_a_dir
                            | hit_b_dat | hit_b_dir;
   wire         hit_any   = hit_ctl | hit_stat | hit_a_pin | hit_b_pin | hit_mem;
   wire [AW-1:0] apb_mem_idx = mem_off[AW+1:2];

   wire [31:0]  reg_rdata =
        hit_cmd   ? {8'h00, cmd_reg} :
        hit_wreg  ? {24'h000000, wreg_reg} :
        hit_flags ? {28'h0000000, flags_reg} :
        hit_stat  ? {31'h0000000, ~idle} :
        hit_a_dat ? {24'h000000, port_a_data_reg} :
        hit_a_dir ? {24'h000000, port_a_dir_reg} :
        hit_b_dat ? {24'h000000, port_b_data_reg} :
        hit_b_dir ? {24'h000000, port_b_dir_reg} :
        hit_a_pin ? {24'h000000, port_a_sync_reg} :
        hit_b_pin ? {24'h000000, port_b_sync_reg} : 32'h00000000;

   // byte lanes without a strobe keep their old register contents; a memory write without pstrb[0] stores zero
   wire [31:0]  wr_val = {pstrb[3] ? pwdata[31:24] : reg_rdata[31:24],
                          pstrb[2] ? pwdata[23:16] : reg_rdata[23:16],
                          pstrb[1] ? pwdata[15:8]  : reg_rdata[15:8],
                          pstrb[0] ? pwdata[7:0]   : reg_rdata[7:0]};

   // memory traffic waits for the engine; control writes while busy are refused
   wire         apb_rd_issue = apb_acc & hit_mem & ~pwrite & idle & ~rd_pend_reg;
   wire         resp_now  = apb_acc & (~hit_mem | (pwrite ? idle : rd_pend_reg));
   wire         resp_err  = ~hit_any | (pwrite & hit_ctl & ~idle);
   wire         commit    = apb_done & pwrite & ~pslverr_reg;
   wire         apb_mem_wr = commit & hit_mem;
   wire         cmd_start = commit & hit_cmd;

   // ----------------------------------------------------------------
   // operation decode
   // ----------------------------------------------------------------
   logic        to_wreg;
   logic        to_mem;
   logic        to_io;
   logic        upd_zero;
   logic        mem_src;
   logic        upd_carry;
   logic [7:0]  result;

   wire [7:0]   bit_mask  = 8'h01 << cmd_reg.bit_idx;
   wire [1:0]   io_sel    = cmd_reg.addr[1:0];
   wire [7:0]   io_cur    = (io_sel == `LBU_IO_A_DATA) ? port_a_data_reg :
                            (io_sel == `LBU_IO_A_DIR)  ? port_a_dir_reg  :
                            (io_sel == `LBU_IO_B_DATA) ? port_b_data_reg : port_b_dir_reg;
   // a direction register has no pin behind it, so it swaps like an output latch
   wire [7:0]   io_dir    = (io_sel == `LBU_IO_A_DATA) ? port_a_dir_reg :
                            (io_sel == `LBU_IO_B_DATA) ? port_b_dir_reg : 8'hff;
   wire [7:0]   io_pin    = (io_sel == `LBU_IO_A_DATA) ? port_a_sync_reg : port_b_sync_reg;
   wire         io_is_out = |(io_dir & bit_mask);
   wire         swap_in   = io_is_out ? |(io_cur & bit_mask)
                                      : |(io_pin & bit_mask);
   wire         imm_form  = cmd_reg.op inside {LBU_OP_AND_I, LBU_OP_OR_I, LBU_OP_XOR_I};
   wire         mw_form   = cmd_reg.op inside {LBU_OP_AND_MW, LBU_OP_OR_MW, LBU_OP_XOR_MW};
   wire [7:0]   opnd      = imm_form ? cmd_reg.imm : mem_rdata;
   wire [7:0]   logic_res = (cmd_reg.op <= LBU_OP_AND_MW) ? (wreg_reg & opnd) :
                            (cmd_reg.op <= LBU_OP_OR_MW)  ? (wreg_reg | opnd) :
                                                            (wreg_reg ^ opnd);
   wire         exec      = (state_reg == LBU_ST_EXEC);
   wire         exec_mem  = exec & to_mem;

   always_comb begin
      to_wreg   = 1'b0;
      to_mem    = 1'b0;
      to_io     = 1'b0;
      upd_zero  = 1'b0;
      mem_src   = 1'b0;
      upd_carry = 1'b0;
      result    = 8'h00;
      case (cmd_reg.op)
         LBU_OP_AND_I, LBU_OP_AND_M, LBU_OP_AND_MW, LBU_OP_OR_I, LBU_OP_OR_M,
         LBU_OP_OR_MW, LBU_OP_XOR_I, LBU_OP_XOR_M, LBU_OP_XOR_MW: begin
            result   = logic_res;
            mem_src  = ~imm_form;
            to_mem   = mw_form;
            to_wreg  = ~mw_form;
            upd_zero = 1'b1;
         end
         LBU_OP_XOR_IO: begin
            result = wreg_reg ^ io_cur;
            to_io  = 1'b1;
         end
         LBU_OP_NOT_W: begin
            result   = ~wreg_reg;
            to_wreg  = 1'b1;
            upd_zero = 1'b1;
         end
         LBU_OP_NOT_M: begin
            result   = ~opnd;
            mem_src  = 1'b1;
            to_mem   = 1'b1;
            upd_zero = 1'b1;
         end
         LBU_OP_NEG_W: begin
            result   = 8'(~wreg_reg + 8'h01);
            to_wreg  = 1'b1;
            upd_zero = 1'b1;
         end
         LBU_OP_NEG_M: begin
            result   = 8'(~opnd + 8'h01);
            mem_src  = 1'b1;
            to_mem   = 1'b1;
            upd_zero = 1'b1;
         end
         LBU_OP_BCLR_IO: begin
            result = io_cur & ~bit_mask;
            to_io  = 1'b1;
         end
         LBU_OP_BSET_IO: begin
            result = io_cur | bit_mask;
            to_io  = 1'b1;
         end
         LBU_OP_SWAPC_IO: begin
            result    = flags_reg.carry ? (io_cur | bit_mask)
                                        : (io_cur & ~bit_mask);
            to_io     = 1'b1;
            upd_carry = 1'b1;
         end
         LBU_OP_BCLR_M: begin
            result  = opnd & ~bit_mask;
            mem_src = 1'b1;
            to_mem  = 1'b1;
         end
         LBU_OP_BSET_M: begin
            result  = opnd | bit_mask;
            mem_src = 1'b1;
            to_mem  = 1'b1;
         end
         default: begin
            result = 8'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // engine sequencing: fetch always takes one cycle so every op lasts the same
   // ----------------------------------------------------------------
   always_comb begin
      case (state_reg)
         LBU_ST_IDLE:  state_next = cmd_start ? LBU_ST_FETCH : LBU_ST_IDLE;
         LBU_ST_FETCH: state_next = LBU_ST_EXEC;
         LBU_ST_EXEC:  state_next = LBU_ST_IDLE;
         default:      state_next = LBU_ST_IDLE;
      endcase
   end

   wire         fetch_re  = (state_reg == LBU_ST_FETCH) & mem_src;
   wire [AW-1:0] eng_idx  = cmd_reg.addr[AW-1:0];

   lbu_mem #(
      .DEPTH (MEM_DEPTH),
      .AW    (AW)
   ) u_mem (
      .pclk  (pclk),
      .re    (fetch_re | apb_rd_issue),
      .we    (exec_mem | apb_mem_wr),
      .addr  (idle ? apb_mem_idx : eng_idx),
      .wdata (exec_mem ? result : wr_val[7:0]),
      .rdata (mem_rdata)
   );

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= LBU_ST_IDLE;
         cmd_reg   <= lbu_cmd_t'(`LBU_CMD_RST);
      end else begin
         state_reg <= state_next;
         if (cmd_start)
            cmd_reg <= lbu_cmd_t'(wr_val[`LBU_CMD_WIDTH-1:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wreg_reg  <= `LBU_WREG_RST;
         flags_reg <= lbu_flags_t'(`LBU_FLAGS_RST);
      end else if (exec) begin
         if (to_wreg)
            wreg_reg <= result;
         if (upd_zero)
            flags_reg.zero <= (result == 8'h00);
         if (upd_carry)
            flags_reg.carry <= swap_in;
      end else if (commit & hit_wreg) begin
         wreg_reg <= wr_val[7:0];
      end else if (commit & hit_flags) begin
         flags_reg <= lbu_flags_t'(wr_val[3:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {port_a_data_reg, port_a_dir_reg, port_b_data_reg, port_b_dir_reg} <= {4{`LBU_PORT_RST}};
      end else begin
         if ((exec & to_io & (io_sel == `LBU_IO_A_DATA)) | (commit & hit_a_dat))
            port_a_data_reg <= exec ? result : wr_val[7:0];
         if ((exec & to_io & (io_sel == `LBU_IO_A_DIR)) | (commit & hit_a_dir))
            port_a_dir_reg <= exec ? result : wr_val[7:0];
         if ((exec & to_io & (io_sel == `LBU_IO_B_DATA)) | (commit & hit_b_dat))
            port_b_data_reg <= exec ? result : wr_val[7:0];
         if ((exec & to_io & (io_sel == `LBU_IO_B_DIR)) | (commit & hit_b_dir))
            port_b_dir_reg <= exec ? result : wr_val[7:0];
      end
   end

   // pins are asynchronous: two flops before anything looks at them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {port_a_meta_reg, port_a_sync_reg, port_b_meta_reg, port_b_sync_reg} <= 32'h00000000;
      end else begin
         port_a_meta_reg <= port_a_in;
         port_a_sync_reg <= port_a_meta_reg;
         port_b_meta_reg <= port_b_in;
         port_b_sync_reg <= port_b_meta_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {rd_pend_reg, pready_reg, pslverr_reg} <= 3'h0;
         prdata_reg  <= 32'h00000000;
      end else begin
         rd_pend_reg <= apb_rd_issue;
         pready_reg  <= resp_now;
         pslverr_reg <= resp_now & resp_err;
         if (resp_now) begin
            prdata_reg <= (pwrite | resp_err) ? 32'h00000000 :
                          hit_mem ? {24'h000000, mem_rdata} : reg_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata     = prdata_reg;
   assign pready     = pready_reg;
   assign pslverr    = pslverr_reg;
   assign port_a_out = port_a_data_reg;
   assign port_a_oe  = port_a_dir_reg;
   assign port_b_out = port_b_data_reg;
   assign port_b_oe  = port_b_dir_reg;
endmodule

`default_nettype wire

//--- testbench/lbu_pin_model.sv
// pin-side partner: each port pin follows the block when enabled, else the outside level
// assumes: no pull resistors, outside level held by the bench
`timescale 1ns/1ps
`default_nettype none
module lbu_pin_model (
   // block side
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   // outside world
   input  wire logic [7:0] ext,
   output logic      [7:0] pin_in
);
   // an enabled pin reads back the latch, so a swap on it returns the latch bit into carry
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

//--- testbench/lbu_top_sva.sv
// checker of apb answers and port outputs of lbu_top
// assumes: bound to lbu_top, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module lbu_top_sva #(
   parameter int MEM_DEPTH = 64
) (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // ports
   input wire logic [7:0]  port_a_out,
   input wire logic [7:0]  port_b_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic setup   = psel && !penable;
   wire logic wr_done = pready && pwrite;
   wire logic is_mem  = paddr >= 12'h100 && paddr < 12'h100 + 12'(4 * MEM_DEPTH);
   // ----------------------------------------------------------------
   // answers
   // ----------------------------------------------------------------
   a_rdy_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_rdy_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_rdy: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> $stable(prdata))
      else $error("prdata moved outside answer");
   a_wr_zero: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("prdata not zero on write answer");
   a_reg_answer: assert property (setup && paddr < 12'h100 |-> ##2 pready)
      else $error("register answer not two cycles after setup");
   a_mem_wait: assert property (setup && is_mem && !pwrite |-> ##2 !pready)
      else $error("memory read answered too early");
   // outputs move only right after a write, or when a command finishes
   a_aout_cause: assert property ($changed(port_a_out) && $past(presetn) |->
      $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
      else $error("port a latch changed without cause");
   a_boe_cause: assert property ($changed(port_b_oe) && $past(presetn) |->
      $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
      else $error("port b direction changed without cause");
   c_err: cover property (pslverr);
   c_mem_rd: cover property (pready && !pwrite && is_mem);
   c_dir: cover property ($changed(port_b_oe));
endmodule
bind lbu_top lbu_top_sva #(.MEM_DEPTH(MEM_DEPTH)) i_lbu_top_sva (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_a_out(port_a_out),
   .port_b_oe(port_b_oe));
`default_nettype wire

//--- testbench/lbu_top_tb.sv
// self-checking bench of lbu_top: apb master, answer scoreboard, reference model
// assumes: lbu_pkg, lbu_map.svh, lbu_pin_model and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "lbu_map.svh"
module lbu_top_tb import lbu_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  a_in, a_out, a_oe, b_in, b_out, b_oe, a_ext, b_ext, w;
   logic [7:0]  io[4];
   logic [7:0]  mem[64];
   logic [3:0]  fl;
   logic [44:0] note_q[$];
   int          errors, tests_run;
   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end
   lbu_top #(.MEM_DEPTH(64)) i_lbu_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_a_in(a_in),
      .port_a_out(a_out), .port_a_oe(a_oe), .port_b_in(b_in), .port_b_out(b_out),
      .port_b_oe(b_oe));
   lbu_pin_model i_pin_a (.pin_out(a_out), .pin_oe(a_oe), .ext(a_ext), .pin_in(a_in));
   lbu_pin_model i_pin_b (.pin_out(b_out), .pin_oe(b_oe), .ext(b_ext), .pin_in(b_in));
   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [44:0] g, input logic [44:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // each note holds address, pslverr and read data of one transfer
   task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d,
                      input logic [32:0] e);
      note_q.push_back({a, e});
      psel    <= 1'h1;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk iff pready === 1'h1);
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'h1, d, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'h0, 32'h0, {1'h0, e});
   endtask
   always @(posedge pclk) begin
      if (pready === 1'h1) begin
         if (note_q.size() == 0)
            chk("apb note", 45'h0, 45'h1);
         else
            chk("apb answer", {paddr, pslverr, prdata}, note_q.pop_front());
      end
   end
   function automatic logic [7:0] lf(input logic [4:0] op, input logic [7:0] x, y);
      case (op / 3)
         5'h0: lf = x & y;
         5'h1: lf = x | y;
         default: lf = x ^ y;
      endcase
   endfunction
   task automatic run_op(input logic [4:0] op, input logic [2:0] bi, input logic [7:0] imm,
                         input logic [7:0] ad);
      logic [7:0] r;
      logic [1:0] s;
      logic [5:0] k;
      logic       t;
      lbu_cmd_t   cmd;
      s = ad[1:0];
      k = ad[5:0];
      r = 8'h0;
      cmd = '{addr: ad, imm: imm, bit_idx: bi, op: lbu_op_t'(op)};
      wr(`LBU_CMD_OFF, {8'h0, cmd});
      repeat (2) @(posedge pclk);
      case (op)
         5'h00, 5'h03, 5'h06: r = lf(op, w, imm);
         5'h01, 5'h02, 5'h04, 5'h05, 5'h07, 5'h08: r = lf(op, w, mem[k]);
         5'h09: io[s] = io[s] ^ w;
         5'h0a, 5'h0b: r = ~(op[0] ? mem[k] : w);
         5'h0c, 5'h0d: r = -(op[0] ? mem[k] : w);
         5'h0e, 5'h0f: io[s][bi] = op[0];
         5'h10: begin
            t = fl[1];
            fl[1] = (s[0] || io[s + 1][bi]) ? io[s][bi] : (s[1] ? b_ext[bi] : a_ext[bi]);
            io[s][bi] = t;
         end
         5'h11, 5'h12: mem[k][bi] = ~op[0];
         default: ;
      endcase
      if (op <= 5'h0d && op != 5'h09) begin
         if (op inside {5'h02, 5'h05, 5'h08, 5'h0b, 5'h0d})
            mem[k] = r;
         else
            w = r;
         fl[0] = (r == 8'h0);
      end
      rd(`LBU_WREG_OFF, {24'h0, w});
      rd(`LBU_FLAGS_OFF, {28'h0, fl});
      rd(`LBU_MEM_BASE + {4'h0, k, 2'h0}, {24'h0, mem[k]});
      for (int i = 0; i < 4; i++)
         rd(`LBU_A_DATA_OFF + 12'(4 * i), {24'h0, io[i]});
      chk("port pins", {13'h0, a_out, a_oe, b_out, b_oe}, {13'h0, io[0], io[1], io[2], io[3]});
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (30000) @(posedge pclk);
      errors++;
      report_and_stop();
   end
   initial begin
      logic [31:0] x;
      logic [7:0]  ad;
      {psel, penable, pwrite, presetn, paddr, pwdata, a_ext, b_ext} = '0;
      {errors, tests_run, w, fl} = '0;
      io = '{default: 8'h0};
      void'($urandom(32'h51ea));
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      for (int i = 0; i < 10; i++)
         rd(12'(4 * i), 32'h0);
      apb(12'h0fc, 1'h0, 32'h0, {1'h1, 32'h0});
      wr(`LBU_STATUS_OFF, 32'h1);
      for (int rn = 0; rn < 4; rn++) begin
         a_ext <= (rn == 0) ? 8'h0 : 8'($urandom);
         b_ext <= (rn == 0) ? 8'h0 : 8'($urandom);
         for (int i = 0; i < 4; i++) begin
            io[i] = (rn == 0) ? 8'h0 : 8'($urandom);
            wr(`LBU_A_DATA_OFF + 12'(4 * i), {24'h0, io[i]});
         end
         for (int op = 0; op < 20; op++) begin
            x  = (rn == 0) ? 32'h0 : $urandom;
            ad = 8'($urandom);
            w  = x[7:0];
            fl = x[11:8];
            mem[ad[5:0]] = x[31:24];
            wr(`LBU_WREG_OFF, {24'h0, w});
            wr(`LBU_FLAGS_OFF, {28'h0, fl});
            wr(`LBU_MEM_BASE + {4'h0, ad[5:0], 2'h0}, {24'h0, mem[ad[5:0]]});
            run_op(5'(op), x[14:12], x[23:16], ad);
         end
         rd(`LBU_A_PIN_OFF, {24'h0, (io[1] & io[0]) | (~io[1] & a_ext)});
         rd(`LBU_B_PIN_OFF, {24'h0, (io[3] & io[2]) | (~io[3] & b_ext)});
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
